// >>> hdl/bci_core.sv
// execution core for a subset of an 8-bit microcontroller instruction set
// Summary of operation
// - OR accumulator with file register; destination bit picks target; zero flag updated
// - copy accumulator into addressed file register; flags untouched
// - copy file register to accumulator or itself; zero flag updated
// - load 8-bit literal into accumulator; flags untouched
// - copy accumulator into timer option register; flags untouched
// - return: literal into accumulator, program counter from stack top
// - return takes two cycles; prefetched instruction discarded
// - sleep sets timeout flag high and clears power-down flag
// - sleep clears watchdog and prescaler; pin-change wake flag kept
// - after sleep the core halts and executes nothing until wake_i releases it
`timescale 1ns/1ps
module bci_core
   import bci_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic instr_valid_i,
   input wire logic [11:0] instr_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic [10:0] stack_top_i,
   input wire logic wake_i,
   input wire logic pin_change_wake_flag_i,
   output logic [4:0] file_addr_o,
   output logic file_we_o,
   output logic [7:0] file_wdata_o,
   output logic [7:0] acc_o,
   output logic zero_flag_o,
   output logic timeout_flag_n_o,
   output logic powerdown_flag_n_o,
   output logic [7:0] timer_cfg_o,
   output logic [7:0] watchdog_counter_o,
   output logic [7:0] prescaler_o,
   output logic pin_change_wake_flag_o,
   output logic [10:0] pc_o,
   output logic stack_pop_o,
   output logic flush_o,
   output logic sleeping_o,
   output logic illegal_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] faddr;
      logic fwe;
      logic [7:0] fwdata;
      logic [7:0] acc;
      logic zero;
      logic tmo_n;
      logic pwrdn_n;
      logic [7:0] tcfg;
      logic [7:0] wdog;
      logic [7:0] pre;
      logic wake_flag;
      logic [10:0] pc;
      logic pop;
      logic flush;
      logic sleeping;
      logic illegal;
   } bci_state_s;

   bci_state_s st_r;
   bci_state_s st_nxt;
   logic known;
   bci_kind_e kind;
   logic [7:0] or_res;
   logic dest_file;
   logic execute;

   // zero test shared by the or and file-copy paths and by the file-to-accumulator copy check
   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction : is_zero

   bci_decode u_decode (
      .instr_i(instr_i),
      .known_o(known),
      .kind_o(kind)
   );

   // file read is combinational on the address field of the current word
   assign or_res = acc_o | file_rdata_i;
   assign dest_file = instr_i[BCI_DEST_BIT];
   // the flushed slot and a sleeping core both ignore the presented word
   assign execute = instr_valid_i && !st_r.flush && !st_r.sleeping;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.fwe = 1'b0;
      st_nxt.pop = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.illegal = 1'b0;
      st_nxt.faddr = instr_i[BCI_FADDR_MSB:0];
      st_nxt.wake_flag = pin_change_wake_flag_i;
      // prescaler counts every cycle while awake; watchdog steps each time it wraps from FF
      if (!st_r.sleeping) begin
         st_nxt.pre = st_r.pre + 8'h01;
         if (st_r.pre == 8'hFF) begin
            st_nxt.wdog = st_r.wdog + 8'h01;
         end
      end
      if (st_r.sleeping) begin
         // wake handling beyond release is outside this core
         if (wake_i) begin
            st_nxt.sleeping = 1'b0;
         end
      end else if (instr_valid_i && st_r.flush) begin
         st_nxt.pc = st_r.pc + 11'h001;
      end else if (execute) begin
         st_nxt.pc = st_r.pc + 11'h001;
         st_nxt.illegal = !known;
         unique case (kind)
            BCI_K_IDLE: begin
            end
            BCI_K_OR: begin
               st_nxt.zero = is_zero(or_res);
               if (dest_file) begin
                  st_nxt.fwe = 1'b1;
                  st_nxt.fwdata = or_res;
               end else begin
                  st_nxt.acc = or_res;
               end
            end
            BCI_K_COPY_ACC: begin
               st_nxt.fwe = 1'b1;
               st_nxt.fwdata = st_r.acc;
            end
            BCI_K_COPY_FILE: begin
               st_nxt.zero = is_zero(file_rdata_i);
               if (dest_file) begin
                  st_nxt.fwe = 1'b1;
                  st_nxt.fwdata = file_rdata_i;
               end else begin
                  st_nxt.acc = file_rdata_i;
               end
            end
            BCI_K_LIT: begin
               st_nxt.acc = instr_i[7:0];
            end
            BCI_K_OPT: begin
               st_nxt.tcfg = st_r.acc;
            end
            BCI_K_RET: begin
               st_nxt.acc = instr_i[7:0];
               st_nxt.pc = stack_top_i;
               st_nxt.pop = 1'b1;
               st_nxt.flush = 1'b1;
            end
            BCI_K_SLEEP: begin
               st_nxt.tmo_n = 1'b1;
               st_nxt.pwrdn_n = 1'b0;
               st_nxt.wdog = BCI_WATCHDOG_CLEAR;
               st_nxt.pre = BCI_PRESCALE_CLEAR;
               st_nxt.sleeping = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_r <= '{faddr: 5'h00, fwe: 1'b0, fwdata: 8'h00, acc: BCI_ACC_RST, zero: 1'b0,
                   tmo_n: 1'b1, pwrdn_n: 1'b1, tcfg: BCI_TIMER_CFG_RST, wdog: BCI_WATCHDOG_CLEAR,
                   pre: BCI_PRESCALE_CLEAR, wake_flag: 1'b0, pc: BCI_PC_RST, pop: 1'b0,
                   flush: 1'b0, sleeping: 1'b0, illegal: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign file_addr_o = st_r.faddr;
   assign file_we_o = st_r.fwe;
   assign file_wdata_o = st_r.fwdata;
   assign acc_o = st_r.acc;
   assign zero_flag_o = st_r.zero;
   assign timeout_flag_n_o = st_r.tmo_n;
   assign powerdown_flag_n_o = st_r.pwrdn_n;
   assign timer_cfg_o = st_r.tcfg;
   assign watchdog_counter_o = st_r.wdog;
   assign prescaler_o = st_r.pre;
   assign pin_change_wake_flag_o = st_r.wake_flag;
   assign pc_o = st_r.pc;
   assign stack_pop_o = st_r.pop;
   assign flush_o = st_r.flush;
   assign sleeping_o = st_r.sleeping;
   assign illegal_o = st_r.illegal;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_OR_DEST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_OR && !dest_file) |=> (acc_o == $past(or_res)) && !file_we_o)
      else $error("or result not in accumulator");
   AST_OR_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_OR) |=> (zero_flag_o == ($past(or_res) == 8'h00)))
      else $error("or zero flag wrong");
   AST_COPY_ACC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_COPY_ACC) |=> file_we_o && (file_wdata_o == $past(acc_o)) && $stable(zero_flag_o))
      else $error("accumulator copy to file wrong");
   AST_COPY_FILE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_COPY_FILE && dest_file) |=> file_we_o && (zero_flag_o == (file_wdata_o == 8'h00)))
      else $error("file copy zero flag wrong");
   AST_LIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_LIT) |=> (acc_o == $past(instr_i[7:0])) && $stable(zero_flag_o))
      else $error("literal load wrong");
   AST_OPT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_OPT) |=> (timer_cfg_o == $past(acc_o)))
      else $error("timer option load wrong");
   AST_RET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_RET) |=> (pc_o == $past(stack_top_i)) && stack_pop_o)
      else $error("return did not load pc");
   AST_RET_FLUSH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_RET) ##1 instr_valid_i |=> $stable(acc_o) && !file_we_o)
      else $error("prefetched word executed after return");
   AST_SLEEP_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_SLEEP) |=> timeout_flag_n_o && !powerdown_flag_n_o)
      else $error("sleep flags wrong");
   AST_SLEEP_WDT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_SLEEP) |=> (watchdog_counter_o == 8'h00) && (prescaler_o == 8'h00))
      else $error("watchdog not cleared by sleep");
   AST_SLEEP_HALT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (sleeping_o && !wake_i) |=> $stable(pc_o) && $stable(acc_o) && sleeping_o)
      else $error("core ran while asleep");
   AST_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_IDLE && known) |=> (pc_o == $past(pc_o) + 11'h001) && $stable(acc_o) && !file_we_o)
      else $error("idle changed state");
   AST_OR_FILE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_OR && dest_file)
      |=> file_we_o && (file_wdata_o == $past(or_res)) && (file_addr_o == $past(instr_i[BCI_FADDR_MSB:0])))
      else $error("or result not written back to file");
   AST_COPY_ACC_ADDR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_COPY_ACC)
      |=> (file_addr_o == $past(instr_i[BCI_FADDR_MSB:0])) && $stable(acc_o) && $stable(powerdown_flag_n_o))
      else $error("accumulator copy went to the wrong register");
   AST_COPY_FILE_ACC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_COPY_FILE && !dest_file)
      |=> (acc_o == $past(file_rdata_i)) && (zero_flag_o == is_zero(acc_o)) && !file_we_o)
      else $error("file copy to accumulator wrong");
   AST_COPY_FILE_SELF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_COPY_FILE && dest_file)
      |=> (file_wdata_o == $past(file_rdata_i)) && $stable(acc_o) && file_we_o)
      else $error("file copy to itself wrong");
   AST_LIT_QUIET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_LIT)
      |=> !file_we_o && $stable(timeout_flag_n_o) && $stable(powerdown_flag_n_o) && $stable(timer_cfg_o))
      else $error("literal load disturbed other state");
   AST_OPT_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_OPT)
      |=> $stable(zero_flag_o) && $stable(acc_o) && !file_we_o)
      else $error("timer option load disturbed other state");
   AST_RET_ACC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_RET)
      |=> (acc_o == $past(instr_i[7:0])) && $stable(zero_flag_o))
      else $error("return literal not in accumulator");
   AST_POP_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      stack_pop_o
      |=> !stack_pop_o)
      else $error("stack pop held too long");
   AST_RET_SKIP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_RET) ##1 instr_valid_i
      |=> (pc_o == $past(pc_o) + 11'h001) && !flush_o && !stack_pop_o)
      else $error("discarded slot mishandled");
   AST_FLUSH_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      flush_o
      |=> !flush_o)
      else $error("discard marker held too long");
   AST_FLAGS_KEPT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind != BCI_K_SLEEP)
      |=> $stable(timeout_flag_n_o) && $stable(powerdown_flag_n_o))
      else $error("power status flags changed outside sleep");
   AST_WAKE_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rst_b_i
      |=> (pin_change_wake_flag_o == $past(pin_change_wake_flag_i)))
      else $error("pin change wake flag altered");
   AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_SLEEP)
      |=> sleeping_o && !file_we_o && !stack_pop_o)
      else $error("sleep not entered");
   AST_SLEEP_QUIET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sleeping_o
      |=> !file_we_o && !stack_pop_o && !illegal_o && $stable(timer_cfg_o))
      else $error("core acted while asleep");
   AST_SLEEP_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (sleeping_o && !wake_i)
      |=> $stable(watchdog_counter_o) && $stable(prescaler_o))
      else $error("watchdog ran while asleep");
   AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (sleeping_o && wake_i)
      |=> !sleeping_o)
      else $error("wake request ignored");
   AST_ILLEGAL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && !known)
      |=> illegal_o && (pc_o == $past(pc_o) + 11'h001) && $stable(acc_o) && !file_we_o)
      else $error("unsupported word not treated as idle");
   AST_IDLE_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (execute && kind == BCI_K_IDLE && known)
      |=> $stable(zero_flag_o) && $stable(timer_cfg_o) && !stack_pop_o && !illegal_o)
      else $error("idle disturbed other state");
endmodule : bci_core

// >>> hdl/bci_pkg.sv
// constants and types shared by the instruction subset core
package bci_pkg;
   // 12-bit instruction encodings of the subset
   localparam logic [11:0] BCI_OP_IDLE = 12'h000;
   localparam logic [11:0] BCI_OP_LOAD_TIMER_CFG = 12'h002;
   localparam logic [11:0] BCI_OP_SLEEP = 12'h003;
   localparam logic [5:0] BCI_OPC_COPY_ACC_TO_FILE = 6'h00;
   localparam logic [6:0] BCI_OPC_COPY_ACC_TO_FILE_HI = 7'h01;
   localparam logic [5:0] BCI_OPC_OR_ACC_INTO_FILE = 6'h04;
   localparam logic [5:0] BCI_OPC_COPY_FILE = 6'h08;
   localparam logic [3:0] BCI_OPC_RETURN_WITH_LITERAL = 4'h8;
   localparam logic [3:0] BCI_OPC_LOAD_LITERAL = 4'hC;
   // field positions
   localparam int BCI_DEST_BIT = 5;
   localparam int BCI_FADDR_MSB = 4;
   // reset values
   localparam logic [7:0] BCI_ACC_RST = 8'h00;
   localparam logic [7:0] BCI_TIMER_CFG_RST = 8'hFF;
   localparam logic [7:0] BCI_WATCHDOG_CLEAR = 8'h00;
   localparam logic [7:0] BCI_PRESCALE_CLEAR = 8'h00;
   localparam logic [10:0] BCI_PC_RST = 11'h000;
   typedef enum logic [2:0] {
      BCI_K_IDLE, BCI_K_OR, BCI_K_COPY_ACC, BCI_K_COPY_FILE, BCI_K_LIT, BCI_K_OPT, BCI_K_RET, BCI_K_SLEEP
   } bci_kind_e;
endpackage : bci_pkg

// >>> hdl/bci_decode.sv
// combinational decoder for the supported instruction subset
`timescale 1ns/1ps
module bci_decode
   import bci_pkg::*;
(
   input wire logic [11:0] instr_i,
   output logic known_o,
   output bci_kind_e kind_o
);
   always_comb begin
      known_o = 1'b1;
      kind_o = BCI_K_IDLE;
      if (instr_i == BCI_OP_IDLE) begin
         kind_o = BCI_K_IDLE;
      end else if (instr_i == BCI_OP_LOAD_TIMER_CFG) begin
         kind_o = BCI_K_OPT;
      end else if (instr_i == BCI_OP_SLEEP) begin
         kind_o = BCI_K_SLEEP;
      end else if (instr_i[11:5] == BCI_OPC_COPY_ACC_TO_FILE_HI) begin
         kind_o = BCI_K_COPY_ACC;
      end else if (instr_i[11:6] == BCI_OPC_OR_ACC_INTO_FILE) begin
         kind_o = BCI_K_OR;
      end else if (instr_i[11:6] == BCI_OPC_COPY_FILE) begin
         kind_o = BCI_K_COPY_FILE;
      end else if (instr_i[11:8] == BCI_OPC_RETURN_WITH_LITERAL) begin
         kind_o = BCI_K_RET;
      end else if (instr_i[11:8] == BCI_OPC_LOAD_LITERAL) begin
         kind_o = BCI_K_LIT;
      end else begin
         known_o = 1'b0;
      end
   end
endmodule : bci_decode

// >>> tb/tb_top.sv
// self-checking testbench for the instruction subset core
`timescale 1ns/1ps
module tb_top;
   import bci_pkg::*;
   // ----------------------------------------
   // signals, clock, design
   // ----------------------------------------
   logic clk_i, rst_b_i, instr_valid_i, wake_i, pin_change_wake_flag_i;
   logic [11:0] instr_i;
   logic [7:0] file_rdata_i;
   logic [10:0] stack_top_i;
   logic [4:0] file_addr_o;
   logic file_we_o, zero_flag_o, timeout_flag_n_o, powerdown_flag_n_o, pin_change_wake_flag_o;
   logic [7:0] file_wdata_o, acc_o, timer_cfg_o, watchdog_counter_o, prescaler_o;
   logic [10:0] pc_o;
   logic stack_pop_o, flush_o, sleeping_o, illegal_o;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [10:0] exp_pc = 11'h000;
   bci_core uut (.clk_i, .rst_b_i, .instr_valid_i, .instr_i, .file_rdata_i, .stack_top_i, .wake_i,
      .pin_change_wake_flag_i, .file_addr_o, .file_we_o, .file_wdata_o, .acc_o, .zero_flag_o,
      .timeout_flag_n_o, .powerdown_flag_n_o, .timer_cfg_o, .watchdog_counter_o, .prescaler_o,
      .pin_change_wake_flag_o, .pc_o, .stack_pop_o, .flush_o, .sleeping_o, .illegal_o);
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // a hung handshake would otherwise stall the run forever
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic tally(input bit bad, input string what);
      n_checks++;
      if (bad) begin
         miscompares++;
         $display("[FAIL] %0t ns: %s", $time, what);
      end
   endtask : tally
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      tally(got !== exp, what);
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp, input string what);
      tally(got !== exp, what);
   endtask : chk_bit
   task automatic chk_pc(input logic [10:0] exp);
      tally(pc_o !== exp, "program counter");
   endtask : chk_pc
   // one word, results sampled mid-cycle once the answering edge has landed
   task automatic issue(input logic [11:0] w, input logic [7:0] rd);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      file_rdata_i <= rd;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      exp_pc = exp_pc + 11'h001;
   endtask : issue
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_data;
      issue({BCI_OPC_LOAD_LITERAL, 8'h00}, 8'hFF);
      chk_bit(zero_flag_o, 1'b0, "zero after literal 00");
      issue({BCI_OPC_OR_ACC_INTO_FILE, 1'b0, 5'h03}, 8'h00);
      chk_bit(zero_flag_o, 1'b1, "zero after or");
      issue({BCI_OPC_LOAD_LITERAL, 8'hA5}, 8'h00);
      chk_byte(acc_o, 8'hA5, "literal load");
      chk_bit(zero_flag_o, 1'b1, "zero kept by literal");
      issue({BCI_OPC_OR_ACC_INTO_FILE, 1'b1, 5'h1F}, 8'h5A);
      chk_bit(file_we_o, 1'b1, "or write strobe");
      chk_byte({3'h0, file_addr_o}, 8'h1F, "or address");
      chk_byte(file_wdata_o, 8'hFF, "or result");
      chk_byte(acc_o, 8'hA5, "acc kept by or to file");
      chk_bit(zero_flag_o, 1'b0, "zero after or to file");
      issue({BCI_OPC_COPY_ACC_TO_FILE_HI, 5'h10}, 8'h00);
      chk_bit(file_we_o, 1'b1, "copy write strobe");
      chk_byte(file_wdata_o, 8'hA5, "copy data");
      chk_bit(zero_flag_o, 1'b0, "flags kept by copy");
      $display("data moves done");
   endtask : t_data
   task automatic t_copy_file;
      issue({BCI_OPC_COPY_FILE, 1'b0, 5'h05}, 8'h00);
      chk_byte(acc_o, 8'h00, "copy file to acc");
      chk_bit(zero_flag_o, 1'b1, "zero after copy file");
      issue({BCI_OPC_COPY_FILE, 1'b1, 5'h07}, 8'h80);
      chk_bit(file_we_o, 1'b1, "self copy strobe");
      chk_byte(file_wdata_o, 8'h80, "self copy data");
      chk_byte(acc_o, 8'h00, "acc kept by self copy");
      chk_bit(zero_flag_o, 1'b0, "zero after self copy");
      issue(BCI_OP_LOAD_TIMER_CFG, 8'h00);
      chk_byte(timer_cfg_o, 8'h00, "timer option load");
      chk_bit(zero_flag_o, 1'b0, "flags kept by option");
      issue(BCI_OP_IDLE, 8'hFF);
      chk_pc(exp_pc);
      chk_bit(file_we_o, 1'b0, "idle writes nothing");
      chk_byte(acc_o, 8'h00, "idle keeps acc");
      $display("copy, option and idle done");
   endtask : t_copy_file
   task automatic t_return;
      issue({BCI_OPC_COPY_FILE, 1'b0, 5'h02}, 8'h00);
      chk_bit(zero_flag_o, 1'b1, "zero set before return");
      @(posedge clk_i);
      stack_top_i <= 11'h123;
      instr_valid_i <= 1'b1;
      instr_i <= {BCI_OPC_RETURN_WITH_LITERAL, 8'h3C};
      @(posedge clk_i);
      instr_i <= {BCI_OPC_LOAD_LITERAL, 8'h77};
      @(negedge clk_i);
      chk_pc(11'h123);
      chk_bit(stack_pop_o, 1'b1, "stack pop");
      chk_bit(flush_o, 1'b1, "flush after return");
      chk_byte(acc_o, 8'h3C, "return literal");
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk_byte(acc_o, 8'h3C, "fetched word discarded");
      chk_pc(11'h124);
      chk_bit(zero_flag_o, 1'b1, "flags kept by return");
      exp_pc = 11'h124;
      $display("return done");
   endtask : t_return
   task automatic t_sleep;
      @(posedge clk_i);
      pin_change_wake_flag_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      issue(BCI_OP_SLEEP, 8'h00);
      chk_bit(timeout_flag_n_o, 1'b1, "timeout flag");
      chk_bit(powerdown_flag_n_o, 1'b0, "powerdown flag");
      chk_byte(watchdog_counter_o, 8'h00, "watchdog cleared");
      chk_byte(prescaler_o, 8'h00, "prescaler cleared");
      chk_bit(pin_change_wake_flag_o, 1'b1, "wake flag kept");
      chk_bit(sleeping_o, 1'b1, "asleep");
      issue({BCI_OPC_LOAD_LITERAL, 8'h55}, 8'h00);
      chk_byte(acc_o, 8'h3C, "no execution asleep");
      chk_pc(exp_pc - 11'h001);
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      @(negedge clk_i);
      chk_bit(sleeping_o, 1'b0, "woken");
      $display("sleep done");
   endtask : t_sleep
   task automatic t_illegal_reset;
      issue(12'h001, 8'h00);
      chk_bit(illegal_o, 1'b1, "unsupported word flagged");
      chk_byte(acc_o, 8'h3C, "unsupported word acts as idle");
      chk_pc(11'h126);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      chk_byte(acc_o, BCI_ACC_RST, "acc after reset");
      chk_byte(timer_cfg_o, BCI_TIMER_CFG_RST, "option after reset");
      chk_bit(powerdown_flag_n_o, 1'b1, "powerdown flag after reset");
      chk_pc(BCI_PC_RST);
      issue({BCI_OPC_LOAD_LITERAL, 8'h12}, 8'h00);
      chk_byte(acc_o, 8'h12, "literal after reset");
      $display("unsupported word and reset done");
   endtask : t_illegal_reset
   initial begin
      rst_b_i = 1'b0;
      instr_valid_i = 1'b0;
      instr_i = 12'h000;
      file_rdata_i = 8'h00;
      stack_top_i = 11'h000;
      wake_i = 1'b0;
      pin_change_wake_flag_i = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_data();
      t_copy_file();
      t_return();
      t_sleep();
      t_illegal_reset();
      wrap_up();
   end
endmodule : tb_top
